// [pkg/tpc_map.svh]
// Purpose: register offsets, field positions, codes and reset values of the timer clock unit
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   byte offsets within the block's address window
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

`define TPC_ADDR_W        8
`define TPC_OFS_CRB       8'h08
`define TPC_OFS_CNT2      8'h0c
`define TPC_OFS_PRSC      8'h10
`define TPC_OFS_CKC       8'h14
`define TPC_OFS_CTL       8'h18

`define TPC_CKC_C1_LO     0
`define TPC_CKC_C1_HI     2
`define TPC_CKC_C2_LO     3
`define TPC_CKC_C2_HI     5

`define TPC_CTL_EN        0
`define TPC_CTL_MODE_LO   1
`define TPC_CTL_MODE_HI   2
`define TPC_CTL_TRAIN     3
`define TPC_CTL_TRIG      4
`define TPC_CTL_START     5
`define TPC_CTL_BPOL      6

`define TPC_SRC_NONE      3'h0
`define TPC_SRC_PRESC     3'h1
`define TPC_SRC_BEVT      3'h2
`define TPC_SRC_PACC      3'h3

`define TPC_MODE_1        2'h0
`define TPC_MODE_2        2'h1
`define TPC_MODE_3        2'h2
`define TPC_MODE_4        2'h3

`define TPC_RST_PRSC      8'h00
`define TPC_RST_CKC       6'h00
`define TPC_RST_MODE      2'h0
`define TPC_CNT_MAX       16'hffff
`define TPC_HTRANS_NSEQ   2'h2

`endif

// [pkg/tpc_pkg.sv]
// Purpose: shared types of the timer clock unit
// Assumes: tpc_map.svh holds every number
// Notes:   bus signals travel as packed structs
package tpc_pkg;

	typedef struct packed {
		logic        hsel;
		logic [7:0]  haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} tpc_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} tpc_ahb_rsp_t;

	typedef struct packed {
		logic        en;
		logic [1:0]  mode;
		logic        train;
		logic        trig;
		logic        bpol;
	} tpc_ctl_t;

	// state that reset sets
	typedef struct packed {
		tpc_ctl_t    ctl;
		logic [7:0]  prsc;
		logic [7:0]  prsc_act;
		logic [7:0]  pcnt;
		logic [5:0]  ckc;
		logic        dp_wr;
		logic [7:0]  dp_addr;
		logic [31:0] rdata;
		logic        b_s1;
		logic        b_s2;
		logic        b_s3;
		logic        tick1;
		logic        und2;
		logic        start_p;
	} tpc_state_t;

	// state that reset leaves alone
	typedef struct packed {
		logic [15:0] crb;
		logic [15:0] cnt2;
	} tpc_hold_t;

endpackage

// [hdl/tpc_timer_prescaler.sv]
// Purpose: prescaler, clock select, capture/reload B and second counter of a dual timer
// Assumes: single clock hclk, zero-wait AHB-Lite slave, input B is asynchronous
// Notes:   capture/reload B and counter 2 are not reset
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tpc_map.svh"

// How it works
// - capture/reload B is 16 bits, always readable
// - capture/reload B writes only while enabled
// - reset leaves capture/reload B, counter 2 alone
// - counter 2 readable, writable, reads live count
// - 8-bit prescaler value rewritable any time
// - new prescaler taken at prescaler underflow
// - pulse-train: new value at start or B event
// - tick divides system clock by value plus one
// - counter 1 source in bits 2:0
// - counter 2 source in bits 5:3, same codes
// - code 000b stops the counter
// - B event, pulse accumulate only modes 1, 3
// - mode field 00b/01b/10b/11b decodes modes
module tpc_timer_prescaler
	import tpc_pkg::*;
(
	// clock and reset
	input  logic         hclk,
	input  logic         hresetn,
	// register bus
	input  tpc_ahb_req_t ahb_req,
	output tpc_ahb_rsp_t ahb_rsp,
	// external pin
	input  logic         input_b_pin,
	// to the rest of the timer
	output logic         timer_enable_bit,
	output logic [1:0]   operating_mode_select,
	output logic         first_counter_tick,
	output logic         second_counter_underflow,
	output logic         train_start_pulse,
	output logic [15:0]  capture_reload_b,
	output logic [15:0]  second_counter_value
);

	tpc_state_t r;
	tpc_state_t n;
	tpc_hold_t  h;
	tpc_hold_t  hn;

	logic       wr;
	logic [7:0] wa;
	logic       b_evt;
	logic       b_act;
	logic       ptick;
	logic       tick2;
	logic       ext_ok;
	logic       train_mode;
	logic       start_wr;

	function automatic logic src_tick(
		input logic [2:0] code,
		input logic       pt,
		input logic       be,
		input logic       ba,
		input logic       ok
	);
		logic t;
		t = 1'b0;
		case (code)
			`TPC_SRC_PRESC: t = pt;
			`TPC_SRC_BEVT:  t = ok & be;
			`TPC_SRC_PACC:  t = ok & pt & ba;
			default:        t = 1'b0;
		endcase
		return t;
	endfunction

	always_comb
	begin
		n = r;
		hn = h;
		wr = r.dp_wr;
		wa = r.dp_addr;

		// pin synchroniser, third stage for edge detection
		n.b_s1 = input_b_pin;
		n.b_s2 = r.b_s1;
		n.b_s3 = r.b_s2;
		b_act = r.ctl.bpol ? r.b_s2 : ~r.b_s2;
		b_evt = r.ctl.bpol ? (r.b_s2 & ~r.b_s3) : (~r.b_s2 & r.b_s3);

		ext_ok = (r.ctl.mode == `TPC_MODE_1) || (r.ctl.mode == `TPC_MODE_3);
		train_mode = (r.ctl.mode == `TPC_MODE_1) && r.ctl.train;

		start_wr = wr && (wa == `TPC_OFS_CTL) && ahb_req.hwdata[`TPC_CTL_START];
		n.start_p = start_wr;

		// prescaler counts down; tick every prsc_act+1 cycles
		ptick = r.ctl.en && (r.pcnt == 8'h00);
		if (!r.ctl.en)
		begin
			n.prsc_act = r.prsc;
			n.pcnt = r.prsc;
		end
		else if (train_mode && (start_wr || (r.ctl.trig && b_evt)))
		begin
			n.prsc_act = r.prsc;
			n.pcnt = r.prsc;
		end
		else if (ptick)
		begin
			// in pulse-train the held value survives underflow
			if (train_mode)
			begin
				n.pcnt = r.prsc_act;
			end
			else
			begin
				n.prsc_act = r.prsc;
				n.pcnt = r.prsc;
			end
		end
		else
		begin
			n.pcnt = r.pcnt - 8'h01;
		end

		n.tick1 = r.ctl.en && src_tick(r.ckc[`TPC_CKC_C1_HI:`TPC_CKC_C1_LO],
			ptick, b_evt, b_act, ext_ok);
		tick2 = r.ctl.en && src_tick(r.ckc[`TPC_CKC_C2_HI:`TPC_CKC_C2_LO],
			ptick, b_evt, b_act, ext_ok);

		// counter 2 counts down; mode 3 reloads from capture/reload B
		n.und2 = 1'b0;
		if (tick2)
		begin
			if (h.cnt2 == 16'h0000)
			begin
				n.und2 = 1'b1;
				hn.cnt2 = (r.ctl.mode == `TPC_MODE_3) ? h.crb : `TPC_CNT_MAX;
			end
			else
			begin
				hn.cnt2 = h.cnt2 - 16'h0001;
			end
		end

		// data-phase writes; software write beats the count
		if (wr)
		begin
			if (wa == `TPC_OFS_CRB)
			begin
				if (r.ctl.en)
				begin
					hn.crb = ahb_req.hwdata[15:0];
				end
			end
			else if (wa == `TPC_OFS_CNT2)
			begin
				hn.cnt2 = ahb_req.hwdata[15:0];
			end
			else if (wa == `TPC_OFS_PRSC)
			begin
				n.prsc = ahb_req.hwdata[7:0];
			end
			else if (wa == `TPC_OFS_CKC)
			begin
				n.ckc = ahb_req.hwdata[5:0];
			end
			else if (wa == `TPC_OFS_CTL)
			begin
				n.ctl.en = ahb_req.hwdata[`TPC_CTL_EN];
				n.ctl.mode = ahb_req.hwdata[`TPC_CTL_MODE_HI:`TPC_CTL_MODE_LO];
				n.ctl.train = ahb_req.hwdata[`TPC_CTL_TRAIN];
				n.ctl.trig = ahb_req.hwdata[`TPC_CTL_TRIG];
				n.ctl.bpol = ahb_req.hwdata[`TPC_CTL_BPOL];
			end
		end

		// address phase; read mux sees this cycle's write already
		n.dp_wr = 1'b0;
		n.rdata = 32'h0000_0000;
		if (ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == `TPC_HTRANS_NSEQ))
		begin
			n.dp_wr = ahb_req.hwrite;
			n.dp_addr = ahb_req.haddr;
			if (!ahb_req.hwrite)
			begin
				if (ahb_req.haddr == `TPC_OFS_CRB)
				begin
					n.rdata = {16'h0000, hn.crb};
				end
				else if (ahb_req.haddr == `TPC_OFS_CNT2)
				begin
					n.rdata = {16'h0000, hn.cnt2};
				end
				else if (ahb_req.haddr == `TPC_OFS_PRSC)
				begin
					n.rdata = {24'h00_0000, n.prsc};
				end
				else if (ahb_req.haddr == `TPC_OFS_CKC)
				begin
					n.rdata = {26'h000_0000, n.ckc};
				end
				else if (ahb_req.haddr == `TPC_OFS_CTL)
				begin
					n.rdata = {25'h000_0000, n.ctl.bpol, 1'b0, n.ctl.trig,
						n.ctl.train, n.ctl.mode, n.ctl.en};
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r <= '0;
			r.prsc <= `TPC_RST_PRSC;
			r.prsc_act <= `TPC_RST_PRSC;
			r.pcnt <= `TPC_RST_PRSC;
			r.ckc <= `TPC_RST_CKC;
			r.ctl.mode <= `TPC_RST_MODE;
		end
		else
		begin
			r <= n;
		end
	end

	// no reset here on purpose: contents start undefined
	always_ff @(posedge hclk)
	begin
		h <= hn;
	end

	assign ahb_rsp.hrdata = r.rdata;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;

	assign timer_enable_bit = r.ctl.en;
	assign operating_mode_select = r.ctl.mode;
	assign first_counter_tick = r.tick1;
	assign second_counter_underflow = r.und2;
	assign train_start_pulse = r.start_p;
	assign capture_reload_b = h.crb;
	assign second_counter_value = h.cnt2;

endmodule

// [tb/tpc_chk.sv]
// Purpose: port checks of the timer clock unit
// Assumes: zero-wait slave, write data lands at the end of its data phase
// Notes:   sees only the top ports
`timescale 1ns/1ps
`include "tpc_map.svh"
module tpc_chk
	import tpc_pkg::*;
(
	// clock and reset
	input logic         hclk,
	input logic         hresetn,
	// bus
	input tpc_ahb_req_t ahb_req,
	input tpc_ahb_rsp_t ahb_rsp,
	// timer side
	input logic         timer_enable_bit,
	input logic [1:0]   operating_mode_select,
	input logic         first_counter_tick,
	input logic         second_counter_underflow,
	input logic         train_start_pulse,
	input logic [15:0]  capture_reload_b,
	input logic [15:0]  second_counter_value
);
	logic       rd_q;
	logic       wr_q;
	logic [7:0] a_q;
	wire        tk = ahb_req.hsel && ahb_req.hready && ahb_req.htrans == `TPC_HTRANS_NSEQ;
	wire        w_ctl = wr_q && a_q == `TPC_OFS_CTL;
	wire [15:0] wd = ahb_req.hwdata[15:0];
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			rd_q <= 0;
			wr_q <= 0;
		end
		else
		begin
			rd_q <= tk && !ahb_req.hwrite;
			wr_q <= tk && ahb_req.hwrite;
		end
	always_ff @(posedge hclk)
		a_q <= ahb_req.haddr;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
		else $error("bus answer wrong");
	idle_zero_a: assert property (!rd_q |-> ahb_rsp.hrdata == 0)
		else $error("read data outside data phase");
	resv_zero_a: assert property (rd_q |-> ahb_rsp.hrdata[31:16] == 0)
		else $error("upper bits not zero");
	ctl_load_a: assert property (w_ctl |=> timer_enable_bit == $past(ahb_req.hwdata[0])
		&& operating_mode_select == $past(ahb_req.hwdata[2:1])) else $error("control not loaded");
	ctl_hold_a: assert property (!w_ctl |=> $stable(timer_enable_bit))
		else $error("enable moved");
	start_pulse_a: assert property (train_start_pulse == $past(w_ctl && ahb_req.hwdata[5]))
		else $error("start pulse wrong");
	cnt_write_a: assert property (wr_q && a_q == `TPC_OFS_CNT2 |=> second_counter_value == $past(wd))
		else $error("counter write lost");
	crb_write_a: assert property (wr_q && a_q == `TPC_OFS_CRB && timer_enable_bit
		|=> capture_reload_b == $past(wd)) else $error("reload write lost");
	clock_stop_a: assert property (!timer_enable_bit [*3] |-> !first_counter_tick
		&& !second_counter_underflow) else $error("tick while disabled");
endmodule
bind tpc_timer_prescaler tpc_chk u_tpc_chk (.hclk, .hresetn, .ahb_req, .ahb_rsp,
	.timer_enable_bit, .operating_mode_select, .first_counter_tick,
	.second_counter_underflow, .train_start_pulse, .capture_reload_b, .second_counter_value);

// [tb/tb_tpc_timer_prescaler.sv]
// Purpose: bench of the timer clock unit
// Assumes: zero-wait slave, 125 MHz
// Notes:   gaps between pulses are measured exactly, 300 means none
`timescale 1ns/1ps
`include "tpc_map.svh"
module tb_tpc_timer_prescaler
	import tpc_pkg::*;
;
	logic         hclk = 0;
	logic         hresetn = 0;
	logic         input_b_pin = 0;
	tpc_ahb_req_t q = '0;
	tpc_ahb_req_t req;
	tpc_ahb_rsp_t rsp;
	logic         tick;
	logic         und;
	logic [31:0]  d;
	int           errors = 0;
	int           checks = 0;
	int           cyc = 0;
	int           n;
	always #4 hclk = ~hclk;
	always_comb
	begin
		req = q;
		req.hready = rsp.hreadyout;
	end
	tpc_timer_prescaler u_tpc_timer_prescaler (.hclk, .hresetn, .ahb_req(req), .ahb_rsp(rsp),
		.input_b_pin, .timer_enable_bit(), .operating_mode_select(), .first_counter_tick(tick),
		.second_counter_underflow(und), .train_start_pulse(), .capture_reload_b(),
		.second_counter_value());
	task conclude();
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cmp(string s, logic [31:0] e, logic [31:0] v);
		checks++;
		if (v !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", s, e, v);
		end
	endtask
	task xfer(logic w, logic [7:0] a, logic [31:0] wd);
		q.hsel <= 1;
		q.htrans <= `TPC_HTRANS_NSEQ;
		q.haddr <= a;
		q.hwrite <= w;
		q.hsize <= 3'h2;
		do @(posedge hclk); while (rsp.hreadyout !== 1);
		q.hsel <= 0;
		q.htrans <= 0;
		q.hwdata <= wd;
		do @(posedge hclk); while (rsp.hreadyout !== 1);
		d = rsp.hrdata;
	endtask
	task rd(logic [7:0] a, logic [31:0] e);
		xfer(0, a, 0);
		cmp($sformatf("reg %h", a), e, d);
	endtask
	// cycles to the next pulse of tick or, with s, of underflow
	task nxt(logic s);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while ((s ? und : tick) !== 1 && n < 300);
	endtask
	always @(posedge hclk)
		if (++cyc == 20000)
		begin
			errors++;
			conclude();
		end
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		rd(`TPC_OFS_PRSC, 0);
		rd(`TPC_OFS_CKC, 0);
		xfer(1, 8'h1c, 32'hffff_ffff);
		rd(8'h1c, 0);
		xfer(1, `TPC_OFS_CTL, 8'h01);
		xfer(1, `TPC_OFS_CRB, 32'hffff_1234);
		rd(`TPC_OFS_CRB, 16'h1234);
		xfer(1, `TPC_OFS_CTL, 0);
		xfer(1, `TPC_OFS_CRB, 16'habcd);
		rd(`TPC_OFS_CRB, 16'h1234);
		xfer(1, `TPC_OFS_CNT2, 32'hffff_0777);
		rd(`TPC_OFS_CNT2, 16'h0777);
		xfer(1, `TPC_OFS_PRSC, 32'hffff_ff5a);
		rd(`TPC_OFS_PRSC, 8'h5a);
		xfer(1, `TPC_OFS_CKC, 32'hffff_ffff);
		rd(`TPC_OFS_CKC, 8'h3f);
		for (int m = 0; m < 4; m++)
			xfer(1, `TPC_OFS_CTL, m << 1);
		xfer(1, `TPC_OFS_CKC, 8'h09);
		xfer(1, `TPC_OFS_PRSC, 8'h07);
		xfer(1, `TPC_OFS_CTL, 8'h01);
		nxt(0);
		nxt(0);
		cmp("gap 7", 8, n);
		xfer(1, `TPC_OFS_PRSC, 8'h03);
		nxt(0);
		cmp("old gap", 8, n + 2);
		nxt(0);
		cmp("gap 3", 4, n);
		xfer(1, `TPC_OFS_PRSC, 8'hff);
		nxt(0);
		nxt(0);
		cmp("gap ff", 256, n);
		xfer(1, `TPC_OFS_PRSC, 0);
		nxt(0);
		nxt(0);
		cmp("gap 0", 1, n);
		xfer(1, `TPC_OFS_CKC, 0);
		repeat (3) @(posedge hclk);
		nxt(0);
		cmp("stopped", 300, n);
		// pulse train keeps its held value until a start
		xfer(1, `TPC_OFS_CKC, 8'h09);
		xfer(1, `TPC_OFS_CTL, 8'h09);
		xfer(1, `TPC_OFS_PRSC, 8'h04);
		nxt(0);
		nxt(0);
		cmp("train held", 1, n);
		xfer(1, `TPC_OFS_CTL, 8'h29);
		nxt(0);
		nxt(0);
		cmp("train start", 5, n);
		// trigger on B reloads the held value without a start write
		xfer(1, `TPC_OFS_PRSC, 8'h02);
		xfer(1, `TPC_OFS_CTL, 8'h59);
		input_b_pin <= 1;
		repeat (8) @(posedge hclk);
		nxt(0);
		nxt(0);
		cmp("train trigger", 3, n);
		input_b_pin <= 0;
		xfer(1, `TPC_OFS_CKC, 8'h02);
		xfer(1, `TPC_OFS_CTL, 8'h41);
		input_b_pin <= 1;
		nxt(0);
		cmp("b event", 1, n < 8);
		input_b_pin <= 0;
		xfer(1, `TPC_OFS_CTL, 8'h43);
		input_b_pin <= 1;
		nxt(0);
		cmp("b in mode 2", 300, n);
		xfer(1, `TPC_OFS_CTL, 8'h45);
		xfer(1, `TPC_OFS_PRSC, 8'h03);
		xfer(1, `TPC_OFS_CKC, 8'h03);
		nxt(0);
		nxt(0);
		cmp("accumulate", 4, n);
		input_b_pin <= 0;
		repeat (6) @(posedge hclk);
		nxt(0);
		cmp("b idle", 300, n);
		xfer(1, `TPC_OFS_CRB, 8'h10);
		xfer(1, `TPC_OFS_CNT2, 8'h02);
		xfer(1, `TPC_OFS_PRSC, 8'h01);
		xfer(1, `TPC_OFS_CKC, 8'h08);
		nxt(1);
		nxt(1);
		cmp("reload gap", 34, n);
		conclude();
	end
endmodule
